// file: sim/ldcfg_bank_properties.sv
/* Concurrent checks on the configuration bank ports.
   Assumes one clock domain with a synchronous active-high reset. */
`timescale 1ns/100ps
module ldcfg_bank_properties
  import ldcfg_pkg::*;
(
  input logic core_clk_in,
  input logic reset_in,
  input logic psel_in,
  input logic penable_in,
  input logic pwrite_in,
  input logic [ADDR_W-1:0] paddr_in,
  input logic [31:0] pwdata_in,
  input logic [3:0] pstrb_in,
  input logic [31:0] prdata_out,
  input floppy_in_t floppy_in,
  input uart_in_t uart_one_in,
  input parallel_in_t parallel_in,
  input pin_t floppy_irq_out,
  input pin_t floppy_dack_out,
  input logic floppy_dreq_taken_out,
  input pin_t uart_one_irq_out,
  input pin_t uart_two_irq_out,
  input pin_t parallel_irq_out,
  input pin_t port_dma_request_out,
  input floppy_cfg_t floppy_cfg_out,
  input port_cfg_t port_cfg_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  a_floppy_gate: assert property (
    (!floppy_in.dma_gate_bit || floppy_in.powered_down) |->
    !floppy_irq_out.oe && !floppy_dack_out.oe && !floppy_dreq_taken_out)
    else $error("floppy pins driven while gated");
  a_floppy_select: assert property (
    (!floppy_in.active || !floppy_in.addr_valid ||
    floppy_in.irq_sel == IRQ_NONE) |-> !floppy_irq_out.oe)
    else $error("floppy irq driven while unselected");
  a_uart_gate: assert property (
    (!uart_one_in.uart_irq_gate && !port_cfg_out.share_irq) |->
    !uart_one_irq_out.oe)
    else $error("uart irq driven with gate low");
  a_share_both: assert property (
    (port_cfg_out.share_irq && uart_one_irq_out.oe && uart_two_irq_out.oe)
    |-> uart_one_irq_out.out == uart_two_irq_out.out)
    else $error("shared uart pins differ");
  a_spp_gate: assert property (
    (port_cfg_out.mode == PP_SPP && !parallel_in.port_irq_gate) |->
    !parallel_irq_out.oe)
    else $error("port irq driven with gate low");
  a_ecp_dma: assert property (
    port_dma_request_out.oe |-> parallel_in.ecp_dma_gate &&
    parallel_in.dma_sel inside {3'h1, 3'h2, 3'h3})
    else $error("port dma request driven while gated");
  a_reset_values: assert property (
    $fell(reset_in) |-> floppy_cfg_out.iface_mode == IFACE_AT &&
    floppy_cfg_out.non_burst && port_cfg_out.mode == PP_PRINTER &&
    port_cfg_out.fifo_threshold == 4'h7)
    else $error("defaults missing after reset");
  a_option_write: assert property (
    (psel_in && penable_in && pwrite_in && pstrb_in[0] &&
    paddr_in == 16'h03C4) |=> floppy_cfg_out.force_wp0 == $past(pwdata_in[0]))
    else $error("write protect bit not written");
  a_reserved_zero: assert property (
    (psel_in && penable_in && !pwrite_in && paddr_in == 16'h03CC) |->
    prdata_out == 32'h0)
    else $error("reserved index reads nonzero");
  a_pulse_hold: assert property (
    ($rose(parallel_irq_out.oe) && port_cfg_out.pulsed_irq &&
    port_cfg_out.mode == PP_EPP19) |->
    (parallel_irq_out.oe && !parallel_irq_out.out) [*8])
    else $error("port irq pulse too short");
  c_share: cover property (port_cfg_out.share_irq && uart_two_irq_out.oe);
  c_pulse: cover property ($rose(parallel_irq_out.oe));
  c_dma: cover property (port_dma_request_out.oe);
endmodule // ldcfg_bank_properties

bind ldcfg_bank ldcfg_bank_properties chk (.*);

// file: sim/ldcfg_host.sv
/* APB host model issuing configuration transfers.
   Assumes one clock; the slave raises pready when ready. */
`timescale 1ns/100ps
module ldcfg_host
  import ldcfg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [ADDR_W-1:0] paddr_out,
  output logic [31:0] pwdata_out,
  output logic [3:0] pstrb_out
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = '0;
    pwdata_out = '0;
    pstrb_out = 4'hF;
  end
  // The request stays unchanged until pready is sampled high or 64 cycles have passed.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [7:0] d, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= {24'h0, d};
    @(posedge core_clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 64);
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule // ldcfg_host

// file: sim/logical_device_config_irq_dma_gating_tb.sv
/* Self-checking bench for the configuration bank and its pin gating.
   Assumes the APB host model and the bound property checker. */
`timescale 1ns/100ps
module logical_device_config_irq_dma_gating_tb;
  import ldcfg_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [7:0] r;
    logic [7:0] d;
    logic [7:0] e;
    logic err;
  } row_t;
  logic clk, reset_in, psel, penable, pwrite, pready, pslverr, taken, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  floppy_in_t fin;
  uart_in_t u1, u2;
  parallel_in_t pin;
  pin_t f_irq, f_dack, u1_irq, u2_irq, p_irq, p_dma;
  int num_errors = 0;
  int check_count = 0;
  row_t rows [10] = '{
    '{16'h03C0, 8'h0E, 8'hFF, 8'hCF, 1'b0},
    '{16'h03C4, 8'h00, 8'hFF, 8'h01, 1'b0},
    '{16'h03C8, 8'hFF, 8'h5A, 8'h5A, 1'b0},
    '{16'h03CC, 8'h00, 8'hFF, 8'h00, 1'b0},
    '{16'h03D0, 8'h00, 8'hFF, 8'h5B, 1'b0},
    '{16'h03D4, 8'h00, 8'hA4, 8'h00, 1'b0},
    '{16'h0FC0, 8'h3C, 8'hA5, 8'hA5, 1'b0},
    '{16'h0FC4, 8'h00, 8'hFF, 8'h03, 1'b0},
    '{16'h13C0, 8'h00, 8'hFF, 8'h83, 1'b0},
    '{16'h03D8, 8'h00, 8'h77, 8'h00, 1'b1}};
  ldcfg_host host (.core_clk_in(clk), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .pstrb_out(pstrb));
  ldcfg_bank uut (.core_clk_in(clk), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .floppy_in(fin),
    .uart_one_in(u1), .uart_two_in(u2), .parallel_in(pin),
    .floppy_irq_out(f_irq), .floppy_dack_out(f_dack),
    .floppy_dreq_taken_out(taken), .uart_one_irq_out(u1_irq),
    .uart_two_irq_out(u2_irq), .parallel_irq_out(p_irq),
    .port_dma_request_out(p_dma), .floppy_cfg_out(), .port_cfg_out());
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    reset_in = 1'b1;
    fin = '0;
    u1 = '0;
    u2 = '0;
    pin = '0;
    repeat (16) @(posedge clk);
    reset_in <= 1'b0;
    foreach (rows[i]) begin
      host.xfer(1'b0, rows[i].a, 8'h00, rd, err);
      check(rd, {24'h0, rows[i].r});
      check(err, rows[i].err);
      host.xfer(1'b1, rows[i].a, rows[i].d, rd, err);
      host.xfer(1'b0, rows[i].a, 8'h00, rd, err);
      check(rd, {24'h0, rows[i].e});
    end
    @(posedge clk);
    reset_in <= 1'b1;
    @(posedge clk);
    reset_in <= 1'b0;
    host.xfer(1'b0, 16'h03C0, 8'h00, rd, err);
    check(rd, {24'h0, FLOPPY_MODE_RST});
    fin <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'h6, 3'h2};
    @(negedge clk);
    check({f_irq, f_dack, taken}, 5'b11111);
    @(posedge clk);
    fin.dma_gate_bit <= 1'b0;
    @(negedge clk);
    check({f_irq.oe, f_dack.oe, taken}, 3'b000);
    @(posedge clk);
    fin.dma_gate_bit <= 1'b1;
    fin.powered_down <= 1'b1;
    @(negedge clk);
    check({f_irq.oe, f_dack.oe, taken}, 3'b000);
    @(posedge clk);
    fin.powered_down <= 1'b0;
    fin.irq_sel <= IRQ_NONE;
    u1 <= '{1'b0, 1'b1, 1'b1, 1'b1, 4'h3};
    u2 <= '{1'b1, 1'b1, 1'b1, 1'b1, IRQ_NONE};
    @(negedge clk);
    check({f_irq.oe, f_dack.oe}, 2'b01);
    check({u1_irq, u2_irq.oe}, 3'b010);
    host.xfer(1'b1, 16'h13C0, 8'h80, rd, err);
    @(negedge clk);
    check(u1_irq, 2'b11);
    @(posedge clk);
    u2.irq_sel <= 4'h4;
    @(negedge clk);
    check({u1_irq, u2_irq}, 4'b1111);
    host.xfer(1'b1, 16'h13C0, 8'h00, rd, err);
    u1.uart_irq_gate <= 1'b0;
    @(negedge clk);
    check(u1_irq.oe, 1'b0);
    host.xfer(1'b1, 16'h0FC0, {1'b0, 4'h7, PP_SPP}, rd, err);
    pin <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1, 4'h7, 3'h1};
    @(negedge clk);
    check(p_irq.oe, 1'b0);
    @(posedge clk);
    pin.port_irq_gate <= 1'b1;
    @(negedge clk);
    check(p_irq.oe, 1'b1);
    host.xfer(1'b1, 16'h0FC0, {1'b0, 4'h7, PP_ECP}, rd, err);
    for (int m = 0; m < 8; m++) begin
      pin.port_irq_gate <= 1'b0;
      pin.ecr_mode <= 3'(m);
      @(negedge clk);
      check(p_irq.oe, (m == 2 || m == 3 || m == 6));
      @(posedge clk);
    end
    check(p_dma.oe, 1'b0);
    pin.ecp_dma_gate <= 1'b1;
    @(negedge clk);
    check(p_dma.oe, 1'b1);
    @(posedge clk);
    pin.dma_sel <= 3'h4;
    @(negedge clk);
    check(p_dma.oe, 1'b0);
    host.xfer(1'b1, 16'h0FC0, {1'b1, 4'h7, PP_EPP19}, rd, err);
    pin.nack <= 1'b0;
    pin.port_irq_gate <= 1'b1;
    @(posedge clk);
    pin.nack <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(p_irq, 2'b01);
    repeat (PULSE_CYCLES) @(posedge clk);
    @(negedge clk);
    check(p_irq.oe, 1'b0);
    complete_run();
  end
endmodule // logical_device_config_irq_dma_gating_tb

// file: verilog/ldcfg_bank.sv
/*
 * Vendor configuration registers of the floppy, parallel and first serial
 * units over APB, and gating of their interrupt and DMA pins.
 * Assumes the unit cores and pads sit outside, synchronous to
 * core_clk_in; reset_in is the hard reset.
 *
 */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps

// Summary of operation
// RULE1: Unit register bits also disable IRQ and DACK.
// RULE2: Floppy pins float when gate clear or powered down.
// RULE3: Serial interrupt floats while uart gate is low; with the share bit set, the code drives it while the other UART's gate is high.
// RULE4: SPP/EPP parallel interrupt floats while gate low.
// RULE5: ECP: DMA by ecp gate, IRQ per ECR mode.
// RULE6: Only hard reset restores these register defaults.
// RULE7: Floppy mode bits: enhanced mode and non-burst DMA.
// RULE8: Floppy interface field, AT mode by default.
// RULE9: Floppy output drive type and tri-state bits.
// RULE10: Drive type register, four two-bit fields, all ones.
// RULE11: Index F3 of floppy reads zero, read only.
// RULE12: Per-drive type, rate table, precompensation disable.
// RULE13: Parallel mode field decodes seven port modes.
// RULE14: ECP FIFO threshold field defaults to seven.
// RULE15: Parallel interrupt pulsed or level per bit seven; the code ignores bit seven and stays level in printer and SPP modes.
// RULE16: Port floppy multiplex field routes drive pins.
// RULE17: Serial mode holds MIDI and high-speed enables.
// RULE18: Serial bit seven selects shared UART interrupt.
// RULE19: Host sets levels before setting the share bit.
// RULE20: Shared with two pins: either UART drives both.
// RULE21: Floppy option bit zero forces write protect.
// RULE22: Unselected interrupt and DMA pins stay floating.
// RULE23: Reserved bits ignore writes and read zero.
module ldcfg_bank
  import ldcfg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire floppy_in_t floppy_in,
  input wire uart_in_t uart_one_in,
  input wire uart_in_t uart_two_in,
  input wire parallel_in_t parallel_in,
  output pin_t floppy_irq_out,
  output pin_t floppy_dack_out,
  output logic floppy_dreq_taken_out,
  output pin_t uart_one_irq_out,
  output pin_t uart_two_irq_out,
  output pin_t parallel_irq_out,
  output pin_t port_dma_request_out,
  output floppy_cfg_t floppy_cfg_out,
  output port_cfg_t port_cfg_out
);

  state_t state_reg;
  state_t state_next;

  logic [2:0] unit;
  logic [7:0] index;
  logic hit;
  logic [7:0] read_byte;
  logic setup_phase;
  logic access_phase;
  logic [7:0] wbyte;

  logic floppy_enabled;

  logic [2:0] pp_mode;

  logic ecp_operation;

  logic basic_operation;

  logic ecr_irq_on;

  logic pp_irq_enabled;

  logic pp_irq_source;

  logic pp_pulsed;

  logic pp_irq_selected;

  logic u1_selected;
  logic u2_selected;

  logic u1_enabled;
  logic u2_enabled;

  logic u1_request;
  logic u2_request;

  logic share;

  assign unit = paddr_in[UNIT_LSB +: 3];
  assign index = paddr_in[INDEX_LSB +: 8];
  assign setup_phase = psel_in && !penable_in;
  assign access_phase = psel_in && penable_in;
  assign wbyte = pwdata_in[7:0];

  // Address decode and read mux; absent and reserved bits read zero.
  always_comb begin
    hit = 1'b0;
    read_byte = 8'h00;
    if (paddr_in[1:0] == 2'b00 &&
        paddr_in[ADDR_W-1:UNIT_LSB+3] == '0) begin
      case (unit)
        UNIT_FLOPPY: begin
          case (index)
            IDX_MODE: begin
              hit = 1'b1;
              read_byte = state_reg.floppy_mode;
            end
            IDX_OPTION: begin
              hit = 1'b1;
              read_byte = state_reg.floppy_option;
            end
            IDX_TYPES: begin
              hit = 1'b1;
              read_byte = state_reg.floppy_drive_types;
            end
            IDX_RESERVED: begin
              hit = 1'b1;
              read_byte = 8'h00; // RULE11
            end
            IDX_DRIVE_ZERO: begin
              hit = 1'b1;
              read_byte = state_reg.drive_zero_parameters;
            end
            IDX_DRIVE_ONE: begin
              hit = 1'b1;
              read_byte = state_reg.drive_one_parameters;
            end
            default: begin
              hit = 1'b0;
            end
          endcase
        end
        UNIT_PARALLEL: begin
          if (index == IDX_MODE) begin
            hit = 1'b1;
            read_byte = state_reg.parallel_mode;
          end else if (index == IDX_OPTION) begin
            hit = 1'b1;
            read_byte = state_reg.parallel_mode_two;
          end
        end
        UNIT_SERIAL_ONE: begin
          if (index == IDX_MODE) begin
            hit = 1'b1;
            read_byte = state_reg.serial_one_mode;
          end
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  // Pin gating terms.
  assign pp_mode = state_reg.parallel_mode[PM_MODE_LSB +: 3];
  assign ecp_operation = pp_mode == PP_ECP || pp_mode == PP_ECP_EPP19 ||
                         pp_mode == PP_ECP_EPP17; // RULE13
  assign basic_operation = pp_mode == PP_PRINTER || pp_mode == PP_SPP;
  assign ecr_irq_on = parallel_in.ecr_mode == ECR_FIFO ||
                      parallel_in.ecr_mode == ECR_ECP ||
                      parallel_in.ecr_mode == ECR_TEST;
  assign pp_irq_selected = parallel_in.irq_sel != IRQ_NONE &&
                           parallel_in.active && parallel_in.addr_valid;
  always_comb begin
    if (ecp_operation) begin
      pp_irq_enabled = ecr_irq_on || parallel_in.port_irq_gate; // RULE5
    end else begin
      pp_irq_enabled = parallel_in.port_irq_gate; // RULE4
    end
  end
  // Level interrupt in ECP-based modes, acknowledge-following otherwise.
  assign pp_irq_source = ecp_operation ? parallel_in.ecp_intr
                                       : parallel_in.nack; // RULE15
  assign pp_pulsed = state_reg.parallel_mode[PM_PULSED] &&
                     !basic_operation; // RULE15

  assign floppy_enabled = floppy_in.dma_gate_bit &&
                          !floppy_in.powered_down &&
                          floppy_in.active && floppy_in.addr_valid; // RULE2

  assign u1_selected = uart_one_in.irq_sel != IRQ_NONE &&
                       uart_one_in.active && uart_one_in.addr_valid;
  assign u2_selected = uart_two_in.irq_sel != IRQ_NONE &&
                       uart_two_in.active && uart_two_in.addr_valid;
  assign u1_request = uart_one_in.irq && uart_one_in.uart_irq_gate; // RULE3
  assign u2_request = uart_two_in.irq && uart_two_in.uart_irq_gate; // RULE3
  assign share = state_reg.serial_one_mode[SM_SHARE];
  // With sharing, a UART that has no level of its own still drives the
  // pin of its partner; the host may keep one UART at no level.
  assign u1_enabled = u1_selected && (uart_one_in.uart_irq_gate ||
                      (share && uart_two_in.uart_irq_gate)); // RULE18
  assign u2_enabled = u2_selected && (uart_two_in.uart_irq_gate ||
                      (share && uart_one_in.uart_irq_gate)); // RULE18

  always_comb begin
    state_next = state_reg;
    state_next.irq_src_prev = pp_irq_source;
    if (state_reg.pulse_count != 5'h00) begin
      state_next.pulse_count = state_reg.pulse_count - 5'h01;
    end
    if (pp_pulsed && pp_irq_enabled && pp_irq_selected &&
        pp_irq_source && !state_reg.irq_src_prev) begin
      state_next.pulse_count = PULSE_COUNT; // RULE15
    end

    if (setup_phase) begin
      state_next.rdata = {24'h000000, read_byte};
      state_next.slverr = !hit;
    end

    if (access_phase && pwrite_in && hit && pstrb_in[0]) begin
      case (unit)
        UNIT_FLOPPY: begin
          case (index)
            IDX_MODE: begin
              state_next.floppy_mode = wbyte & FLOPPY_MODE_MASK; // RULE23
            end
            IDX_OPTION: begin
              state_next.floppy_option = wbyte & FLOPPY_OPTION_MASK;
            end
            IDX_TYPES: begin
              state_next.floppy_drive_types =
                wbyte & FLOPPY_TYPES_MASK; // RULE10
            end
            IDX_DRIVE_ZERO: begin
              state_next.drive_zero_parameters =
                wbyte & DRIVE_PARAM_MASK; // RULE12
            end
            IDX_DRIVE_ONE: begin
              state_next.drive_one_parameters = wbyte & DRIVE_PARAM_MASK;
            end
            default: begin
            end
          endcase
        end
        UNIT_PARALLEL: begin
          if (index == IDX_MODE) begin
            state_next.parallel_mode = wbyte & PARALLEL_MODE_MASK;
          end else begin
            state_next.parallel_mode_two =
              wbyte & PARALLEL_MODE_TWO_MASK; // RULE16
          end
        end
        default: begin
          state_next.serial_one_mode = wbyte & SERIAL_MODE_MASK; // RULE17
        end
      endcase
    end
  end

  // Only the hard reset restores the defaults; nothing else clears them.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_reg.floppy_mode <= FLOPPY_MODE_RST; // RULE6
      state_reg.floppy_option <= FLOPPY_OPTION_RST;
      state_reg.floppy_drive_types <= FLOPPY_TYPES_RST;
      state_reg.drive_zero_parameters <= DRIVE_PARAM_RST;
      state_reg.drive_one_parameters <= DRIVE_PARAM_RST;
      state_reg.parallel_mode <= PARALLEL_MODE_RST; // RULE14
      state_reg.parallel_mode_two <= PARALLEL_MODE_TWO_RST;
      state_reg.serial_one_mode <= SERIAL_MODE_RST;

      state_reg.rdata <= 32'h00000000;
      state_reg.slverr <= 1'b0;
      state_reg.pulse_count <= 5'h00;
      state_reg.irq_src_prev <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // APB answer: read data is captured in the setup cycle.
  assign pready_out = access_phase;
  assign prdata_out = state_reg.rdata;
  assign pslverr_out = access_phase && state_reg.slverr;

  // Floppy pins float unless every enable of the unit agrees.
  always_comb begin
    floppy_irq_out.out = floppy_in.irq;
    floppy_irq_out.oe = floppy_enabled &&
                        floppy_in.irq_sel != IRQ_NONE; // RULE1
    floppy_dack_out.out = floppy_in.dack;
    floppy_dack_out.oe = floppy_enabled &&
                         floppy_in.dma_sel != 3'h0 &&
                         floppy_in.dma_sel < 3'h4; // RULE22
    floppy_dreq_taken_out = floppy_enabled && floppy_in.dreq; // RULE2
  end

  always_comb begin
    uart_one_irq_out.out = u1_request || (share && u2_request); // RULE20
    uart_one_irq_out.oe = u1_enabled; // RULE22
    uart_two_irq_out.out = u2_request || (share && u1_request); // RULE20
    uart_two_irq_out.oe = u2_enabled; // RULE22
  end

  // Pulsed type: drive low for the pulse, then release to high impedance.
  always_comb begin
    if (!pp_irq_selected || !pp_irq_enabled) begin
      parallel_irq_out.out = 1'b0;
      parallel_irq_out.oe = 1'b0; // RULE22
    end else if (pp_pulsed) begin
      parallel_irq_out.out = 1'b0;
      parallel_irq_out.oe = state_reg.pulse_count != 5'h00; // RULE15
    end else begin
      parallel_irq_out.out = pp_irq_source;
      parallel_irq_out.oe = 1'b1; // RULE4
    end

    port_dma_request_out.out = parallel_in.drq;
    port_dma_request_out.oe = ecp_operation && parallel_in.ecp_dma_gate &&
                              parallel_in.active &&
                              parallel_in.addr_valid &&
                              parallel_in.dma_sel != 3'h0 &&
                              parallel_in.dma_sel < 3'h4; // RULE5
  end

  // Decoded configuration towards the unit cores and pad logic.
  always_comb begin
    floppy_cfg_out.enhanced = state_reg.floppy_mode[FM_ENHANCED]; // RULE7
    floppy_cfg_out.non_burst = state_reg.floppy_mode[FM_NON_BURST]; // RULE7
    floppy_cfg_out.iface_mode =
      state_reg.floppy_mode[FM_IFACE_LSB +: 2]; // RULE8
    // These two steer only the dedicated floppy pads, not the port pads.
    floppy_cfg_out.push_pull = state_reg.floppy_mode[FM_PUSH_PULL]; // RULE9
    floppy_cfg_out.tristate = state_reg.floppy_mode[FM_TRISTATE]; // RULE9
    floppy_cfg_out.force_wp0 =
      state_reg.floppy_option[FO_FORCE_WP0]; // RULE21
    floppy_cfg_out.drive_types = state_reg.floppy_drive_types; // RULE10
    floppy_cfg_out.drive_zero_type =
      state_reg.drive_zero_parameters[DP_TYPE_LSB +: 2];
    floppy_cfg_out.drive_zero_rate =
      state_reg.drive_zero_parameters[DP_RATE_LSB +: 2];
    floppy_cfg_out.drive_zero_precomp_disable =
      state_reg.drive_zero_parameters[DP_PRECOMP_OFF]; // RULE12
    floppy_cfg_out.drive_one_type =
      state_reg.drive_one_parameters[DP_TYPE_LSB +: 2];
    floppy_cfg_out.drive_one_rate =
      state_reg.drive_one_parameters[DP_RATE_LSB +: 2];
    floppy_cfg_out.drive_one_precomp_disable =
      state_reg.drive_one_parameters[DP_PRECOMP_OFF];
  end

  always_comb begin
    port_cfg_out.mode = pp_mode;
    port_cfg_out.fifo_threshold =
      state_reg.parallel_mode[PM_THRESH_LSB +: 4]; // RULE14
    port_cfg_out.pulsed_irq = pp_pulsed;
    port_cfg_out.port_floppy_mux =
      state_reg.parallel_mode_two[PM2_MUX_LSB +: 2];
    port_cfg_out.floppy_split_mux =
      port_cfg_out.port_floppy_mux == MUX_SPLIT; // RULE16
    port_cfg_out.floppy_all_on_port =
      port_cfg_out.port_floppy_mux == MUX_ALL_ON_PORT; // RULE16

    port_cfg_out.midi = state_reg.serial_one_mode[SM_MIDI]; // RULE17
    port_cfg_out.high_speed =
      state_reg.serial_one_mode[SM_HIGH_SPEED]; // RULE17
    port_cfg_out.share_irq = share; // RULE18
  end

endmodule // ldcfg_bank

// file: verilog/ldcfg_pkg.sv
/*
 * Constants, field layouts and carrier types for the logical device
 * configuration bank with its interrupt and DMA pin gating.
 * Assumes a single 50 MHz clock and an APB master with 32-bit data.
 */
package ldcfg_pkg;
  localparam int ADDR_W = 16;
  localparam int CLK_PERIOD_NS = 20;
  // Address layout: byte address = unit number * 0x400 + index * 4.
  localparam int UNIT_LSB = 10;
  localparam int INDEX_LSB = 2;
  localparam logic [2:0] UNIT_FLOPPY = 3'h0;
  localparam logic [2:0] UNIT_PARALLEL = 3'h3;
  localparam logic [2:0] UNIT_SERIAL_ONE = 3'h4;
  localparam logic [7:0] IDX_MODE = 8'hF0;
  localparam logic [7:0] IDX_OPTION = 8'hF1;
  localparam logic [7:0] IDX_TYPES = 8'hF2;
  localparam logic [7:0] IDX_RESERVED = 8'hF3;
  localparam logic [7:0] IDX_DRIVE_ZERO = 8'hF4;
  localparam logic [7:0] IDX_DRIVE_ONE = 8'hF5;
  // Reset values.
  localparam logic [7:0] FLOPPY_MODE_RST = 8'h0E;
  localparam logic [7:0] FLOPPY_OPTION_RST = 8'h00;
  localparam logic [7:0] FLOPPY_TYPES_RST = 8'hFF;
  localparam logic [7:0] DRIVE_PARAM_RST = 8'h00;
  localparam logic [7:0] PARALLEL_MODE_RST = 8'h3C;
  localparam logic [7:0] PARALLEL_MODE_TWO_RST = 8'h00;
  localparam logic [7:0] SERIAL_MODE_RST = 8'h00;
  // Writable bit masks; other bits hold zero.
  localparam logic [7:0] FLOPPY_MODE_MASK = 8'hCF;
  localparam logic [7:0] FLOPPY_OPTION_MASK = 8'h01;
  localparam logic [7:0] FLOPPY_TYPES_MASK = 8'hFF;
  localparam logic [7:0] DRIVE_PARAM_MASK = 8'h5B;
  localparam logic [7:0] PARALLEL_MODE_MASK = 8'hFF;
  localparam logic [7:0] PARALLEL_MODE_TWO_MASK = 8'h03;
  localparam logic [7:0] SERIAL_MODE_MASK = 8'h83;
  // Field positions.
  localparam int FM_ENHANCED = 0;
  localparam int FM_NON_BURST = 1;
  localparam int FM_IFACE_LSB = 2;
  localparam int FM_PUSH_PULL = 6;
  localparam int FM_TRISTATE = 7;
  localparam int FO_FORCE_WP0 = 0;
  localparam int DP_TYPE_LSB = 0;
  localparam int DP_RATE_LSB = 3;
  localparam int DP_PRECOMP_OFF = 6;
  localparam int PM_MODE_LSB = 0;
  localparam int PM_THRESH_LSB = 3;
  localparam int PM_PULSED = 7;
  localparam int PM2_MUX_LSB = 0;
  localparam int SM_MIDI = 0;
  localparam int SM_HIGH_SPEED = 1;
  localparam int SM_SHARE = 7;
  // Encodings.
  localparam logic [1:0] IFACE_AT = 2'b11;
  localparam logic [1:0] MUX_NORMAL = 2'b00;
  localparam logic [1:0] MUX_SPLIT = 2'b01;
  localparam logic [1:0] MUX_ALL_ON_PORT = 2'b10;
  localparam logic [2:0] PP_PRINTER = 3'b100;
  localparam logic [2:0] PP_SPP = 3'b000;
  localparam logic [2:0] PP_EPP19 = 3'b001;
  localparam logic [2:0] PP_EPP17 = 3'b101;
  localparam logic [2:0] PP_ECP = 3'b010;
  localparam logic [2:0] PP_ECP_EPP19 = 3'b011;
  localparam logic [2:0] PP_ECP_EPP17 = 3'b111;
  localparam logic [2:0] ECR_FIFO = 3'b010;
  localparam logic [2:0] ECR_ECP = 3'b011;
  localparam logic [2:0] ECR_TEST = 3'b110;
  localparam logic [3:0] IRQ_NONE = 4'h0;
  // Length of the pulsed-low parallel interrupt.
  localparam int PULSE_NS = 500;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] PULSE_COUNT = 5'(PULSE_CYCLES);

  typedef struct packed {
    logic out;
    logic oe;
  } pin_t;

  typedef struct packed {
    logic irq;
    logic dack;
    logic dreq;
    logic dma_gate_bit;
    logic powered_down;
    logic active;
    logic addr_valid;
    logic [3:0] irq_sel;
    logic [2:0] dma_sel;
  } floppy_in_t;

  typedef struct packed {
    logic irq;
    logic uart_irq_gate;
    logic active;
    logic addr_valid;
    logic [3:0] irq_sel;
  } uart_in_t;

  typedef struct packed {
    logic nack;
    logic ecp_intr;
    logic drq;
    logic port_irq_gate;
    logic ecp_dma_gate;
    logic [2:0] ecr_mode;
    logic active;
    logic addr_valid;
    logic [3:0] irq_sel;
    logic [2:0] dma_sel;
  } parallel_in_t;

  typedef struct packed {
    logic enhanced;
    logic non_burst;
    logic [1:0] iface_mode;
    logic push_pull;
    logic tristate;
    logic force_wp0;
    logic [7:0] drive_types;
    logic [1:0] drive_zero_type;
    logic [1:0] drive_zero_rate;
    logic drive_zero_precomp_disable;
    logic [1:0] drive_one_type;
    logic [1:0] drive_one_rate;
    logic drive_one_precomp_disable;
  } floppy_cfg_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [3:0] fifo_threshold;
    logic pulsed_irq;
    logic [1:0] port_floppy_mux;
    logic floppy_split_mux;
    logic floppy_all_on_port;
    logic midi;
    logic high_speed;
    logic share_irq;
  } port_cfg_t;

  typedef struct packed {
    logic [7:0] floppy_mode;
    logic [7:0] floppy_option;
    logic [7:0] floppy_drive_types;
    logic [7:0] drive_zero_parameters;
    logic [7:0] drive_one_parameters;
    logic [7:0] parallel_mode;
    logic [7:0] parallel_mode_two;
    logic [7:0] serial_one_mode;
    logic [31:0] rdata;
    logic slverr;
    logic [4:0] pulse_count;
    logic irq_src_prev;
  } state_t;
endpackage
